//--- hdl/i2cmg_pkg.sv
package i2cmg_pkg;
    // port mode select codes (4-bit field)
    localparam logic [3:0] MODE_MASTER      = 4'h8;
    localparam logic [3:0] MODE_SLAVE7      = 4'h6;
    localparam logic [3:0] MODE_SLAVE10     = 4'h7;
    // second control register field positions
    localparam int         CON2_GENERAL_CALL_ENABLE_BIT    = 7;
    localparam int         CON2_STOP_BIT    = 2;
    localparam int         CON2_START_BIT   = 0;
    // status register field position
    localparam int         STAT_UA_BIT      = 1;
    // general call address byte
    localparam logic [7:0] GENERAL_CALL_ADR = 8'h00;
    // instruction cycle: 4 system clocks (Q1..Q4)
    localparam logic [1:0] QUARTER_LAST     = 2'h3;
    localparam logic [1:0] QUARTER_Q2       = 2'h1;
    localparam logic [1:0] QUARTER_Q4       = 2'h3;
    localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
    localparam logic [3:0] ACK_BIT_NUM      = 4'h9;
    localparam logic [6:0] RELOAD_RESET     = 7'h00;
endpackage : i2cmg_pkg

//--- hdl/i2cmg_core.sv
`timescale 1ns/10ps
`default_nettype none
module i2cmg_core
    import i2cmg_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // first control register fields
    input  wire logic       port_enable,
    input  wire logic [3:0] port_mode_select,
    // second control register requests
    input  wire logic       general_call_enable,
    input  wire logic       start_request_bit,
    input  wire logic       restart_request,
    input  wire logic       stop_request_bit,
    input  wire logic       receive_request,
    input  wire logic       ack_request,
    input  wire logic       ack_data_value,
    // slave address register and transfer buffer
    input  wire logic [7:0] slave_address_register,
    input  wire logic       address_write,
    input  wire logic       buffer_write,
    input  wire logic [7:0] buffer_wdata,
    input  wire logic       buffer_read,
    input  wire logic       flag_clear,
    input  wire logic       collision_clear,
    // status
    output logic [7:0]      transfer_buffer,
    output logic            buffer_full_flag,
    output logic            port_interrupt_flag,
    output logic            write_collision_flag,
    output logic            update_address_flag,
    output logic            ack_status,
    output logic            start_seen,
    output logic            stop_seen,
    output logic            start_busy,
    output logic            stop_busy,
    output logic            general_call_hit,
    // bus pins, enable low drives low
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            scl_out,
    output logic            scl_oe_n,
    output logic            sda_out,
    output logic            sda_oe_n
);
    typedef enum logic [3:0] {
        I2CMG_IDLE, I2CMG_ST_A, I2CMG_ST_B, I2CMG_RS_A, I2CMG_RS_B, I2CMG_RS_C,
        I2CMG_BIT_LO, I2CMG_BIT_HI, I2CMG_SP_A, I2CMG_SP_B, I2CMG_SP_C, I2CMG_HOLD
    } i2cmg_state_e;

    i2cmg_state_e state;
    logic [1:0]   quarter;
    logic [6:0]   divider;
    logic         div_run;
    logic         scl_s1, scl_s2, sda_s1, sda_s2, scl_d, sda_d;
    logic [7:0]   shift_register;
    logic [3:0]   bit_cnt;
    logic         rx_mode, ack_mode;
    logic         scl_drv_low, sda_drv_low;
    logic         s_active, s_first, s_match;

    // pin synchronisers
    always_ff @(posedge clk_sys)
    begin
        scl_s1 <= scl_in;
        scl_s2 <= scl_s1;
        sda_s1 <= sda_in;
        sda_s2 <= sda_s1;
        scl_d  <= scl_s2;
        sda_d  <= sda_s2;
    end

    wire master_on  = port_enable && (port_mode_select == MODE_MASTER);
    wire slave_on   = port_enable && (port_mode_select == MODE_SLAVE7 ||
                                      port_mode_select == MODE_SLAVE10);
    wire ten_bit    = port_mode_select == MODE_SLAVE10;
    wire scl_rise   = scl_s2 && !scl_d;
    wire scl_fall   = !scl_s2 && scl_d;
    wire bus_start  = scl_s2 && sda_d && !sda_s2;
    wire bus_stop   = scl_s2 && !sda_d && sda_s2;
    wire dec_tick   = (quarter == QUARTER_Q2) || (quarter == QUARTER_Q4);
    wire rollover   = div_run && dec_tick && (divider == 7'h00);
    wire [6:0] reload = slave_address_register[6:0];
    wire idle_state = state == I2CMG_IDLE || state == I2CMG_HOLD;
    wire in_start   = state == I2CMG_ST_A || state == I2CMG_ST_B ||
                      state == I2CMG_RS_A || state == I2CMG_RS_B || state == I2CMG_RS_C;
    wire wr_accept  = buffer_write && idle_state && master_on;
    wire wr_reject  = buffer_write && master_on && !idle_state;
    // scl released but held low elsewhere: divider waits
    wire scl_wait   = !scl_drv_low && !scl_s2;
    wire [7:0] rx_full = {shift_register[6:0], sda_s2};
    wire gc_match   = general_call_enable && rx_full == GENERAL_CALL_ADR;
    wire own_match  = ten_bit ? (rx_full[7:3] == 5'b11110 &&
                                 rx_full[2:1] == slave_address_register[2:1])
                              : (rx_full[7:1] == slave_address_register[7:1]);

    logic         ev_done;
    wire          byte_bit  = bit_cnt == BITS_PER_BYTE;
    // receive ends after eight bits; its acknowledge is a separate request
    wire          byte_end  = ack_mode || (bit_cnt == ACK_BIT_NUM) || (rx_mode && byte_bit);

    // quarter counter and divider
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            quarter <= 2'h0;
        else
            quarter <= quarter + 2'h1;
    end

    wire phase_step = rollover && !scl_wait;

    always_ff @(posedge clk_sys)
    begin
        if (rst || !master_on)
        begin
            divider <= RELOAD_RESET;
            div_run <= 1'b0;
        end
        else if (scl_wait)
            divider <= reload;
        else if (wr_accept || (idle_state && (start_request_bit || stop_request_bit ||
                 restart_request || receive_request || ack_request)))
        begin
            divider <= reload;
            div_run <= 1'b1;
        end
        else if (ev_done)
            div_run <= 1'b0;
        else if (rollover)
            divider <= reload;
        else if (div_run && dec_tick)
            divider <= divider - 7'h01;
    end

    assign ev_done = phase_step && (state == I2CMG_ST_B || state == I2CMG_RS_C ||
                     state == I2CMG_SP_C || (state == I2CMG_BIT_HI && byte_end));

    // master sequencer
    always_ff @(posedge clk_sys)
    begin
        if (rst || !master_on)
        begin
            state       <= I2CMG_IDLE;
            scl_drv_low <= 1'b0;
            sda_drv_low <= 1'b0;
            bit_cnt     <= 4'h0;
            rx_mode     <= 1'b0;
            ack_mode    <= 1'b0;
        end
        else
        begin
            case (state)
                I2CMG_IDLE, I2CMG_HOLD:
                begin
                    if (start_request_bit && scl_s2 && sda_s2)
                        state <= I2CMG_ST_A;
                    else if (restart_request)
                    begin
                        scl_drv_low <= 1'b1;
                        state       <= I2CMG_RS_A;
                    end
                    else if (stop_request_bit)
                    begin
                        scl_drv_low <= 1'b1;
                        sda_drv_low <= 1'b1;
                        state       <= I2CMG_SP_A;
                    end
                    else if (wr_accept || receive_request || ack_request)
                    begin
                        rx_mode  <= receive_request;
                        ack_mode <= ack_request;
                        bit_cnt  <= ack_request ? ACK_BIT_NUM : 4'h1;
                        state    <= I2CMG_BIT_LO;
                    end
                end
                I2CMG_ST_A:
                    if (phase_step)
                    begin
                        sda_drv_low <= 1'b1;
                        state       <= I2CMG_ST_B;
                    end
                I2CMG_ST_B:
                    if (phase_step)
                    begin
                        scl_drv_low <= 1'b1;
                        state       <= I2CMG_HOLD;
                    end
                I2CMG_RS_A:
                    if (phase_step)
                    begin
                        sda_drv_low <= 1'b0;
                        scl_drv_low <= 1'b0;
                        state       <= I2CMG_RS_B;
                    end
                I2CMG_RS_B:
                    if (phase_step)
                    begin
                        sda_drv_low <= 1'b1;
                        state       <= I2CMG_RS_C;
                    end
                I2CMG_RS_C:
                    if (phase_step)
                    begin
                        scl_drv_low <= 1'b1;
                        state       <= I2CMG_HOLD;
                    end
                I2CMG_BIT_LO:
                    if (phase_step)
                    begin
                        scl_drv_low <= 1'b0;
                        state       <= I2CMG_BIT_HI;
                    end
                I2CMG_BIT_HI:
                    if (phase_step)
                    begin
                        scl_drv_low <= 1'b1;
                        bit_cnt     <= bit_cnt + 4'h1;
                        if (byte_end)
                            state <= I2CMG_HOLD;
                        else
                            state <= I2CMG_BIT_LO;
                    end
                I2CMG_SP_A:
                    if (phase_step)
                    begin
                        scl_drv_low <= 1'b0;
                        state       <= I2CMG_SP_B;
                    end
                I2CMG_SP_B:
                    if (phase_step)
                    begin
                        sda_drv_low <= 1'b0;
                        state       <= I2CMG_SP_C;
                    end
                I2CMG_SP_C:
                    if (phase_step)
                        state <= I2CMG_IDLE;
                default:
                    state <= I2CMG_IDLE;
            endcase
            // data bit driven while clock is low
            if (state == I2CMG_BIT_LO && !phase_step)
                // line released to read a bit or the slave's acknowledge
                sda_drv_low <= ack_mode ? !ack_data_value :
                               (!rx_mode && bit_cnt != ACK_BIT_NUM && !shift_register[7]);
        end
    end

    // shift register, buffer and flags
    logic [3:0] s_cnt;
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            shift_register       <= 8'h00;
            transfer_buffer      <= 8'h00;
            buffer_full_flag     <= 1'b0;
            port_interrupt_flag  <= 1'b0;
            write_collision_flag <= 1'b0;
            update_address_flag  <= 1'b0;
            ack_status           <= 1'b0;
            general_call_hit     <= 1'b0;
            s_active             <= 1'b0;
            s_first              <= 1'b0;
            s_match              <= 1'b0;
            s_cnt                <= 4'h0;
        end
        else
        begin
            if (buffer_read)
                buffer_full_flag <= 1'b0;
            if (flag_clear)
                port_interrupt_flag <= 1'b0;
            if (collision_clear)
                write_collision_flag <= 1'b0;
            if (address_write)
                update_address_flag <= 1'b0;
            if (wr_reject)
                write_collision_flag <= 1'b1;
            if (wr_accept)
            begin
                shift_register   <= buffer_wdata;
                transfer_buffer  <= buffer_wdata;
                buffer_full_flag <= 1'b1;
            end
            if (master_on && state == I2CMG_BIT_HI && phase_step && bit_cnt <= BITS_PER_BYTE)
            begin
                shift_register <= {shift_register[6:0], sda_s2};
                if (byte_bit)
                begin
                    if (rx_mode)
                        transfer_buffer <= {shift_register[6:0], sda_s2};
                    buffer_full_flag <= rx_mode;
                end
            end
            if (master_on && state == I2CMG_BIT_HI && phase_step &&
                bit_cnt == ACK_BIT_NUM && !rx_mode && !ack_mode)
                ack_status <= sda_s2;
            if (ev_done)
                port_interrupt_flag <= 1'b1;
            // slave address recognition
            if (!slave_on || bus_stop)
            begin
                s_active <= 1'b0;
            end
            else if (bus_start)
            begin
                s_active         <= 1'b1;
                s_first          <= 1'b1;
                s_match          <= 1'b0;
                general_call_hit <= 1'b0;
                s_cnt            <= 4'h0;
            end
            else if (s_active && s_first && scl_rise && s_cnt < BITS_PER_BYTE)
            begin
                shift_register <= {shift_register[6:0], sda_s2};
                s_cnt          <= s_cnt + 4'h1;
                if (s_cnt == BITS_PER_BYTE - 4'h1 && (gc_match || own_match))
                begin
                    transfer_buffer  <= rx_full;
                    buffer_full_flag <= 1'b1;
                    general_call_hit <= gc_match;
                    s_match          <= 1'b1;
                    if (ten_bit && !gc_match)
                        update_address_flag <= 1'b1;
                end
            end
            else if (s_active && s_first && scl_fall && s_cnt == ACK_BIT_NUM)
            begin
                s_cnt   <= 4'h0;
                s_first <= 1'b0;
                if (s_match)
                    port_interrupt_flag <= 1'b1;
            end
            else if (s_active && s_first && scl_fall && s_cnt == BITS_PER_BYTE)
                s_cnt <= s_cnt + 4'h1;
        end
    end

    // start/stop seen
    always_ff @(posedge clk_sys)
    begin
        if (rst || !port_enable)
        begin
            start_seen <= 1'b0;
            stop_seen  <= 1'b0;
        end
        else if (bus_start)
        begin
            start_seen <= 1'b1;
            stop_seen  <= 1'b0;
        end
        else if (bus_stop)
        begin
            start_seen <= 1'b0;
            stop_seen  <= 1'b1;
        end
    end

    assign start_busy = in_start;
    assign stop_busy  = state == I2CMG_SP_A || state == I2CMG_SP_B || state == I2CMG_SP_C;
    assign scl_out    = 1'b0;
    assign sda_out    = 1'b0;
    assign scl_oe_n   = !(master_on && scl_drv_low);
    assign sda_oe_n   = !(master_on && sda_drv_low);
endmodule : i2cmg_core
`default_nettype wire

//--- verif/i2cmg_props.sv
`timescale 1ns/10ps
`default_nettype none
module i2cmg_props
    import i2cmg_pkg::*;
(
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       rst,
    // controls
    input wire logic       port_enable,
    input wire logic [3:0] port_mode_select,
    input wire logic       general_call_enable,
    input wire logic       buffer_write,
    input wire logic       flag_clear,
    // status and pins
    input wire logic [7:0] transfer_buffer,
    input wire logic       buffer_full_flag,
    input wire logic       port_interrupt_flag,
    input wire logic       write_collision_flag,
    input wire logic       update_address_flag,
    input wire logic       start_seen,
    input wire logic       stop_seen,
    input wire logic       start_busy,
    input wire logic       stop_busy,
    input wire logic       general_call_hit,
    input wire logic       scl_oe_n,
    input wire logic       sda_oe_n
);
    wire logic master_on = port_enable && port_mode_select == MODE_MASTER;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    chk_gc_enable: assert property ($rose(general_call_hit) |-> general_call_enable)
        else $error("general call seen while disabled");
    chk_gc_buffer: assert property ($rose(general_call_hit) |->
        ##[0:2] (transfer_buffer == GENERAL_CALL_ADR && buffer_full_flag))
        else $error("general call byte not held in buffer");
    chk_ua_mode: assert property ($rose(update_address_flag)
        |-> port_mode_select == MODE_SLAVE10) else $error("update flag outside 10-bit mode");
    chk_gc_no_ua: assert property ($rose(general_call_hit) && !update_address_flag
        |-> !update_address_flag [*4]) else $error("update flag set by general call");
    chk_off_clears: assert property (!port_enable ##1 !port_enable
        |-> !start_seen && !stop_seen) else $error("seen bits kept while disabled");
    chk_no_queue: assert property (buffer_write && start_busy
        |=> write_collision_flag && $stable(transfer_buffer)) else $error("write during start");
    chk_start_flag: assert property ($fell(start_busy) && master_on
        |-> ##[0:2] port_interrupt_flag) else $error("no flag after start");
    chk_stop_flag: assert property ($fell(stop_busy) && master_on
        |-> ##[0:2] port_interrupt_flag) else $error("no flag after stop");
    chk_flag_sticky: assert property (port_interrupt_flag && !flag_clear && port_enable
        |=> port_interrupt_flag) else $error("flag dropped without clear");
    chk_slave_quiet: assert property (!master_on ##1 !master_on
        |-> scl_oe_n && sda_oe_n) else $error("lines driven outside master mode");
    chk_scl_low: assert property (master_on && $fell(scl_oe_n)
        |-> !scl_oe_n [*5]) else $error("clock low phase too short");
    chk_scl_high: assert property (master_on && $rose(scl_oe_n)
        |-> scl_oe_n [*6]) else $error("clock high phase too short");
    cover property ($rose(general_call_hit));
    cover property ($rose(write_collision_flag));
    cover property ($rose(update_address_flag));
    cover property ($fell(stop_busy));
endmodule : i2cmg_props
bind i2cmg_core i2cmg_props u_props (.clk_sys, .rst, .port_enable, .port_mode_select,
    .general_call_enable, .buffer_write, .flag_clear, .transfer_buffer, .buffer_full_flag,
    .port_interrupt_flag, .write_collision_flag, .update_address_flag, .start_seen,
    .stop_seen, .start_busy, .stop_busy, .general_call_hit, .scl_oe_n, .sda_oe_n);
`default_nettype wire

//--- verif/i2cmg_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
module i2cmg_slave_model #(
    parameter logic [6:0] ADDR = 7'h52
) (
    // resolved bus lines
    input  wire logic       scl,
    input  wire logic       sda,
    // high means released
    output var logic        scl_rel,
    output var logic        sda_rel,
    // test control and observed data
    input  wire logic       slow,
    input  wire logic [7:0] tx_byte,
    output var logic [7:0]  rx_byte
);
    logic [7:0] sh;
    logic [7:0] tsh;
    logic       sel;
    logic       rd;
    logic       first;
    int         n;
    initial begin
        scl_rel = 1'b1;
        sda_rel = 1'b1;
        rx_byte = 8'h00;
        sel = 1'b0;
        rd = 1'b0;
        first = 1'b1;
        n = 0;
    end
    // start and stop frame the address phase
    always @(negedge sda) if (scl) begin n = 0; sel = 1'b0; first = 1'b1; end
    always @(posedge sda) if (scl) begin n = 0; sel = 1'b0; first = 1'b1; end
    always @(posedge scl) begin
        if (n < 8) sh = {sh[6:0], sda};
        else if (rd && !first && sda) sel = 1'b0;
        n++;
    end
    always @(negedge scl) begin
        sda_rel = 1'b1;
        if (n == 8) begin
            if (first) begin sel = (sh[7:1] == ADDR); rd = sh[0]; end
            if (sel && (!rd || first)) sda_rel = 1'b0;
            if (sel && !rd) rx_byte = sh;
            first = 1'b0;
        end else if (n == 9) begin
            n = 0;
            tsh = tx_byte;
            if (sel && rd) sda_rel = tsh[7];
        end else if (sel && rd && !first && n > 0) sda_rel = tsh[7-n];
        // slow peer holds the clock low after each fall
        // release lands on a falling clk_sys edge, between rising edges
        if (slow) begin scl_rel = 1'b0; #290; scl_rel = 1'b1; end
    end
endmodule : i2cmg_slave_model
`default_nettype wire

//--- verif/i2c_master_general_call_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module i2c_master_general_call_bench;
    import i2cmg_pkg::*;
    typedef struct { logic [7:0] b; logic ack; } i2cmg_row_s;
    logic clk_sys, rst, port_enable, general_call_enable, start_request_bit, restart_request;
    logic stop_request_bit, receive_request, ack_request, ack_data_value, address_write;
    logic buffer_write, buffer_read, flag_clear, collision_clear, slow, bm_scl, bm_sda;
    logic [3:0] port_mode_select;
    logic [7:0] slave_address_register, buffer_wdata, transfer_buffer, rx_byte;
    logic buffer_full_flag, port_interrupt_flag, write_collision_flag, update_address_flag;
    logic ack_status, start_seen, stop_seen, start_busy, stop_busy, general_call_hit;
    logic scl_out, scl_oe_n, sda_out, sda_oe_n, m_scl, m_sda;
    wire logic scl_in = (scl_oe_n | scl_out) & m_scl & bm_scl;
    wire logic sda_in = (sda_oe_n | sda_out) & m_sda & bm_sda;
    int n_fail, checked, k;
    i2cmg_row_s rows [4] = '{'{8'ha4, 1'b0}, '{8'h5a, 1'b0}, '{8'ha5, 1'b0}, '{8'h00, 1'b0}};
    i2cmg_core DUT (.clk_sys, .rst, .port_enable, .port_mode_select, .general_call_enable,
        .start_request_bit, .restart_request, .stop_request_bit, .receive_request,
        .ack_request, .ack_data_value, .slave_address_register, .address_write,
        .buffer_write, .buffer_wdata, .buffer_read, .flag_clear, .collision_clear,
        .transfer_buffer, .buffer_full_flag, .port_interrupt_flag, .write_collision_flag,
        .update_address_flag, .ack_status, .start_seen, .stop_seen, .start_busy,
        .stop_busy, .general_call_hit, .scl_in, .sda_in, .scl_out, .scl_oe_n, .sda_out,
        .sda_oe_n);
    i2cmg_slave_model #(.ADDR(7'h52)) PEER (.scl(scl_in), .sda(sda_in), .scl_rel(m_scl),
        .sda_rel(m_sda), .slow, .tx_byte(8'hc3), .rx_byte);
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic cyc(int c); repeat (c) @(negedge clk_sys); endtask : cyc
    task automatic pulse(ref logic s); s = 1'b1; cyc(1); s = 1'b0; endtask : pulse
    task automatic req(ref logic s); s = 1'b1; cyc(2); s = 1'b0; endtask : req
    task automatic wflag();
        k = 0;
        while (port_interrupt_flag !== 1'b1 && k < 4000) begin cyc(1); k++; end
        `CHK("irq", 1'b1, port_interrupt_flag)
        pulse(flag_clear);
    endtask : wflag
    task automatic wbyte(logic [7:0] b); buffer_wdata = b; pulse(buffer_write); wflag(); endtask : wbyte
    // bench acting as another master, 160 ns per bit
    task automatic bm_bit(logic v); bm_sda = v; #40; bm_scl = 1; #80; bm_scl = 0; #40; endtask : bm_bit
    task automatic gc_try(logic [7:0] b, logic en, logic exp);
        general_call_enable = en;
        bm_sda = 1'b0; #80; bm_scl = 1'b0; #40;
        for (int j = 7; j >= 0; j--) bm_bit(b[j]);
        `CHK("irq early", 1'b0, port_interrupt_flag)
        bm_bit(1'b1);
        bm_sda = 1'b0; #40; bm_scl = 1'b1; #80; bm_sda = 1'b1; #80;
        cyc(4);
        `CHK("slave irq", exp, port_interrupt_flag)
    endtask : gc_try
    task automatic give_verdict();
        if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    initial begin
        {port_enable, general_call_enable, start_request_bit, restart_request} = 4'h0;
        {stop_request_bit, receive_request, ack_request, ack_data_value} = 4'h0;
        {address_write, buffer_write, buffer_read, flag_clear, collision_clear} = 5'h00;
        {slow, bm_scl, bm_sda, rst} = 4'h7;
        n_fail = 0;
        checked = 0;
        buffer_wdata = 8'h00;
        port_mode_select = MODE_MASTER;
        slave_address_register = 8'h02;
        cyc(2);
        rst = 1'b0;
        port_enable = 1'b1;
        req(start_request_bit);
        wflag();
        for (int i = 0; i < 4; i++) begin
            wbyte(rows[i].b);
            `CHK("ack", rows[i].ack, ack_status)
            `CHK("peer rx", rows[i].b, rx_byte)
        end
        req(stop_request_bit);
        wflag();
        `CHK("stop seen", 1'b1, stop_seen)
        slow = 1'b1;
        req(start_request_bit);
        wflag();
        wbyte(8'h22);
        `CHK("nack", 1'b1, ack_status)
        req(restart_request);
        wflag();
        wbyte(8'ha5);
        `CHK("read ack", 1'b0, ack_status)
        req(receive_request);
        wflag();
        `CHK("read data", 8'hc3, transfer_buffer)
        ack_data_value = 1'b1;
        req(ack_request);
        wflag();
        req(stop_request_bit);
        wflag();
        slow = 1'b0;
        start_request_bit = 1'b1;
        k = 0;
        while (start_busy !== 1'b1 && k < 50) begin cyc(1); k++; end
        start_request_bit = 1'b0;
        buffer_wdata = 8'h77;
        pulse(buffer_write);
        `CHK("collision", 1'b1, write_collision_flag)
        `CHK("dropped", 8'hc3, transfer_buffer)
        wflag();
        pulse(collision_clear);
        req(stop_request_bit);
        wflag();
        port_enable = 1'b0;
        cyc(2);
        `CHK("seen off", 2'b00, {start_seen, stop_seen})
        port_mode_select = MODE_SLAVE7;
        slave_address_register = 8'hf2;
        port_enable = 1'b1;
        gc_try(8'h00, 1'b1, 1'b1);
        `CHK("gc buffer", 8'h00, transfer_buffer)
        `CHK("gc bf hit", 2'b11, {buffer_full_flag, general_call_hit})
        pulse(flag_clear);
        pulse(buffer_read);
        gc_try(8'h00, 1'b0, 1'b0);
        gc_try(8'h01, 1'b1, 1'b0);
        port_mode_select = MODE_SLAVE10;
        pulse(address_write);
        gc_try(8'h00, 1'b1, 1'b1);
        `CHK("gc no ua", 1'b0, update_address_flag)
        pulse(flag_clear);
        pulse(buffer_read);
        gc_try(8'hf2, 1'b1, 1'b1);
        `CHK("ua set", 1'b1, update_address_flag)
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        `CHK("reset flags", 4'h0, {port_interrupt_flag, update_address_flag, start_seen, stop_seen})
        `CHK("released", 2'b11, {scl_oe_n, sda_oe_n})
        give_verdict();
    end
    initial begin
        #500000;
        n_fail++;
        give_verdict();
    end
endmodule : i2c_master_general_call_bench
`default_nettype wire
